// ---- rtl/reh_pkg.sv ----
// Constants and types for the receive error handler
`default_nettype none
package reh_pkg;
  // ----------------------------------------
  // Header field positions and codes
  // ----------------------------------------
  localparam int FMT_4DW_BIT = 0;
  localparam int FMT_DATA_BIT = 1;
  localparam int CMD_MEM_EN_BIT = 1;
  localparam logic [11:0] CFG_CMD_OFFSET = 12'h004;
  localparam logic [4:0] TYP_MEM = 5'h00;
  localparam logic [4:0] TYP_MEM_LK = 5'h01;
  localparam logic [4:0] TYP_IO = 5'h02;
  localparam logic [4:0] TYP_CFG0 = 5'h04;
  localparam logic [4:0] TYP_CFG1 = 5'h05;
  localparam logic [4:0] TYP_CPL = 5'h0a;
  localparam logic [4:0] TYP_CPL_LK = 5'h0b;
  localparam logic [1:0] TYP_MSG_TOP = 2'h2;
  localparam logic [31:0] ADDR_HI_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // Completion status and supported messages
  // ----------------------------------------
  localparam logic [2:0] CPL_ST_UR = 3'h1;
  localparam logic [2:0] CPL_ST_CA = 3'h4;
  localparam logic [7:0] MSG_UNLOCK = 8'h00;
  localparam logic [7:0] MSG_PME_OFF = 8'h19;
  localparam logic [7:0] MSG_SLOT_PWR = 8'h50;
  localparam logic [7:0] MSG_VDM0 = 8'h7e;
  localparam logic [7:0] MSG_VDM1 = 8'h7f;
  // ----------------------------------------
  // Buffer and state
  // ----------------------------------------
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [1:0] CNT_ONE = 2'h1;

  typedef struct packed {
    logic [2:0] fmt;
    logic [4:0] typ;
    logic poison;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic [63:0] addr;
    logic [7:0] msg_code;
  } reh_ent_type;

  typedef struct packed {
    reh_ent_type [1:0] ent;
    logic [1:0] cnt;
    logic app_valid;
    logic [15:0] cpl_cmpl_id;
    logic rx_ready;
    logic cpl_valid;
    logic [2:0] cpl_status;
    logic [15:0] cpl_req_id;
    logic [7:0] cpl_tag;
    logic err_poison;
    logic err_ecrc;
    logic err_ur;
    logic err_nonfatal;
  } reh_state_type;
endpackage : reh_pkg
`default_nettype wire

// ---- rtl/reh_rx_error_handler.sv ----
// Receive TLP error screening with completion return and two-entry buffer
//
// Behaviour
// [R1] Poisoned packet: record poisoned error, still forward to application.
// [R2] Application handles forwarded poisoned packets itself.
// [R3] Flag end-to-end CRC error on failed ECRC of a well formed packet.
// [R4] ECRC-failed non-posted request: return completer abort completion.
// [R5] ECRC-failed packets are always dropped, never forwarded.
// [R6] Type 0 configuration request to missing function is unsupported.
// [R7] Completion with requester ID not ours is unsupported.
// [R8] Unsupported messages and Type 1 configuration requests are unsupported.
// [R9] Locked memory read is unsupported on a native endpoint.
// [R10] Locked completion is unsupported.
// [R11] 64-bit memory request with zero upper address is unsupported.
// [R12] Memory or I/O request hitting no base window is unsupported.
// [R13] Memory request while memory space disabled is unsupported.
// [R14] Poisoned Type 0 configuration write is unsupported, not poisoned.
// [R15] Unsupported non-posted gets UR completion; all unsupported dropped.
// [R16] ECRC and unsupported errors reported as uncorrectable non-fatal.
`default_nettype none
module reh_rx_error_handler
  import reh_pkg::*;
#(
  parameter int NUM_BAR = 2,
  parameter int NUM_FUNC = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Received packets from the link
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [2:0] rx_fmt,
  input wire logic [4:0] rx_type,
  input wire logic rx_poison,
  input wire logic rx_ecrc_err,
  input wire logic [15:0] rx_req_id,
  input wire logic [7:0] rx_tag,
  input wire logic [63:0] rx_addr,
  input wire logic [2:0] rx_func,
  input wire logic [7:0] rx_msg_code,
  // Configuration state
  input wire logic [15:0] cfg_bdf,
  input wire logic [15:0] cfg_command,
  input wire logic [NUM_BAR-1:0][63:0] bar_base,
  input wire logic [NUM_BAR-1:0][63:0] bar_mask,
  input wire logic [NUM_BAR-1:0] bar_is_io,
  input wire logic [NUM_BAR-1:0] bar_en,
  // Forwarded packets to the application
  output logic app_valid,
  input wire logic app_ready,
  output logic [2:0] app_fmt,
  output logic [4:0] app_type,
  output logic app_poison,
  output logic [15:0] app_req_id,
  output logic [7:0] app_tag,
  output logic [63:0] app_addr,
  output logic [7:0] app_msg_code,
  // Generated completions
  output logic cpl_valid,
  input wire logic cpl_ready,
  output logic [2:0] cpl_status,
  output logic [15:0] cpl_req_id,
  output logic [7:0] cpl_tag,
  output logic [15:0] cpl_cmpl_id,
  // Error events
  output logic err_poison,
  output logic err_ecrc,
  output logic err_ur,
  output logic err_nonfatal
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic bar_match(input logic [63:0] addr, input logic want_io,
                                     input logic [NUM_BAR-1:0][63:0] base,
                                     input logic [NUM_BAR-1:0][63:0] mask,
                                     input logic [NUM_BAR-1:0] is_io,
                                     input logic [NUM_BAR-1:0] en);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_BAR; i++) begin
      if (en[i] && (is_io[i] == want_io) && ((addr & mask[i]) == (base[i] & mask[i]))) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic msg_known(input logic [7:0] code);
    return (code == MSG_UNLOCK) || (code == MSG_PME_OFF) || (code == MSG_SLOT_PWR) ||
           (code == MSG_VDM0) || (code == MSG_VDM1);
  endfunction

  // ----------------------------------------
  // Packet decode
  // ----------------------------------------
  logic has_data;
  logic is_4dw;
  logic is_mem;
  logic is_mem_lk;
  logic is_io;
  logic is_cfg0;
  logic is_cfg1;
  logic is_cpl;
  logic is_cpl_lk;
  logic is_msg;
  logic non_posted;
  logic ur_hit;
  logic mem_space_on;
  reh_ent_type rx_ent;

  assign has_data = rx_fmt[FMT_DATA_BIT];
  assign is_4dw = rx_fmt[FMT_4DW_BIT];
  assign is_mem = (rx_type == TYP_MEM);
  assign is_mem_lk = (rx_type == TYP_MEM_LK);
  assign is_io = (rx_type == TYP_IO);
  assign is_cfg0 = (rx_type == TYP_CFG0);
  assign is_cfg1 = (rx_type == TYP_CFG1);
  assign is_cpl = (rx_type == TYP_CPL);
  assign is_cpl_lk = (rx_type == TYP_CPL_LK);
  assign is_msg = (rx_type[4:3] == TYP_MSG_TOP);
  assign mem_space_on = cfg_command[CMD_MEM_EN_BIT];
  assign non_posted = !is_msg && !is_cpl && !is_cpl_lk && !(is_mem && has_data);

  always_comb begin
    ur_hit = 1'b0;
    if (is_cfg0 && (32'(rx_func) >= NUM_FUNC)) begin
      ur_hit = 1'b1; // [R6]
    end
    if (is_cpl && (rx_req_id != cfg_bdf)) begin
      ur_hit = 1'b1; // [R7]
    end
    if ((is_msg && !msg_known(rx_msg_code)) || is_cfg1) begin
      ur_hit = 1'b1; // [R8]
    end
    if (is_mem_lk) begin
      ur_hit = 1'b1; // [R9]
    end
    if (is_cpl_lk) begin
      ur_hit = 1'b1; // [R10]
    end
    if (is_mem && is_4dw && (rx_addr[63:32] == ADDR_HI_ZERO)) begin
      ur_hit = 1'b1; // [R11]
    end
    if ((is_mem || is_io) && !bar_match(rx_addr, is_io, bar_base, bar_mask, bar_is_io, bar_en)) begin
      ur_hit = 1'b1; // [R12]
    end
    if (is_mem && !mem_space_on) begin
      ur_hit = 1'b1; // [R13]
    end
    if (is_cfg0 && has_data && rx_poison) begin
      ur_hit = 1'b1; // [R14]
    end
  end

  always_comb begin
    rx_ent.fmt = rx_fmt;
    rx_ent.typ = rx_type;
    rx_ent.poison = rx_poison;
    rx_ent.req_id = rx_req_id;
    rx_ent.tag = rx_tag;
    rx_ent.addr = rx_addr;
    rx_ent.msg_code = rx_msg_code;
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  reh_state_type s_r;
  reh_state_type s_nxt;
  logic take;
  logic pop;

  assign take = rx_valid && s_r.rx_ready;
  assign pop = (s_r.cnt != 2'h0) && app_ready;

  always_comb begin
    s_nxt = s_r;
    s_nxt.err_poison = 1'b0;
    s_nxt.err_ecrc = 1'b0;
    s_nxt.err_ur = 1'b0;
    s_nxt.err_nonfatal = 1'b0;
    if (s_r.cpl_valid && cpl_ready) begin
      s_nxt.cpl_valid = 1'b0;
    end
    if (pop) begin
      s_nxt.ent[0] = s_r.ent[1];
      s_nxt.cnt = 2'(s_r.cnt - CNT_ONE);
    end
    if (take) begin
      if (rx_ecrc_err) begin
        s_nxt.err_ecrc = 1'b1; // [R3] [R5]
        s_nxt.err_nonfatal = 1'b1; // [R16]
        if (non_posted) begin
          s_nxt.cpl_valid = 1'b1; // [R4]
          s_nxt.cpl_status = CPL_ST_CA;
          s_nxt.cpl_cmpl_id = cfg_bdf;
          s_nxt.cpl_req_id = rx_req_id;
          s_nxt.cpl_tag = rx_tag;
        end
      end else if (ur_hit) begin
        s_nxt.err_ur = 1'b1; // [R15]
        s_nxt.err_nonfatal = 1'b1; // [R16]
        if (non_posted) begin
          s_nxt.cpl_valid = 1'b1; // [R15]
          s_nxt.cpl_status = CPL_ST_UR;
          s_nxt.cpl_cmpl_id = cfg_bdf;
          s_nxt.cpl_req_id = rx_req_id;
          s_nxt.cpl_tag = rx_tag;
        end
      end else begin
        s_nxt.err_poison = rx_poison; // [R1]
        s_nxt.ent[s_nxt.cnt[0]] = rx_ent; // [R1]
        s_nxt.cnt = 2'(s_nxt.cnt + CNT_ONE);
      end
    end
    // Stall while full or while a completion waits
    s_nxt.rx_ready = (s_nxt.cnt != BUF_DEPTH) && !s_nxt.cpl_valid;
    // Head valid kept as its own flop so the port comes straight from a register
    s_nxt.app_valid = (s_nxt.cnt != 2'h0);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rx_ready = s_r.rx_ready;
  assign app_valid = s_r.app_valid;
  assign app_fmt = s_r.ent[0].fmt;
  assign app_type = s_r.ent[0].typ;
  assign app_poison = s_r.ent[0].poison; // [R2]
  assign app_req_id = s_r.ent[0].req_id;
  assign app_tag = s_r.ent[0].tag;
  assign app_addr = s_r.ent[0].addr;
  assign app_msg_code = s_r.ent[0].msg_code;
  assign cpl_valid = s_r.cpl_valid;
  assign cpl_status = s_r.cpl_status;
  assign cpl_req_id = s_r.cpl_req_id;
  assign cpl_tag = s_r.cpl_tag;
  assign cpl_cmpl_id = s_r.cpl_cmpl_id;
  assign err_poison = s_r.err_poison;
  assign err_ecrc = s_r.err_ecrc;
  assign err_ur = s_r.err_ur;
  assign err_nonfatal = s_r.err_nonfatal;

endmodule // reh_rx_error_handler
`default_nettype wire

// ---- test/reh_app_model.sv ----
// Application side model with random back-pressure
`default_nettype none
module reh_app_model (
  // Clock and reset
  input wire logic clk, reset_n,
  // Handshakes
  input wire logic stall,
  output logic app_ready, cpl_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Poisoned packets are accepted like any other; their handling stays here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      app_ready <= 1'b0;
      cpl_ready <= 1'b0;
    end else begin
      app_ready <= !stall || ($urandom % 4 == 0);
      cpl_ready <= !stall || ($urandom % 3 == 0);
    end
  end
endmodule // reh_app_model
`default_nettype wire

// ---- test/reh_rx_error_handler_asserts.sv ----
// Assertion checker for the receive error handler
`default_nettype none
module reh_rx_error_handler_chk
  import reh_pkg::*;
#(
  parameter int NUM_BAR = 2,
  parameter int NUM_FUNC = 1
) (
  // Clock and reset
  input wire logic clk, reset_n,
  // Link side and configuration
  input wire logic rx_valid, rx_ready, rx_poison, rx_ecrc_err,
  input wire logic [2:0] rx_fmt, rx_func,
  input wire logic [4:0] rx_type,
  input wire logic [15:0] rx_req_id, cfg_bdf, cfg_command,
  input wire logic [63:0] rx_addr,
  // Application side and events
  input wire logic app_valid, cpl_valid, cpl_ready,
  input wire logic [2:0] cpl_status,
  input wire logic err_poison, err_ecrc, err_ur, err_nonfatal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire tk = rx_valid && rx_ready;
  wire ok = tk && !rx_ecrc_err;
  wire mrd = rx_type == TYP_MEM && !rx_fmt[FMT_DATA_BIT];
  ecrc_flag_a: assert property (tk && rx_ecrc_err |=> err_ecrc && err_nonfatal && !err_ur)
    else $error("ecrc flag wrong");
  ecrc_abort_a: assert property (tk && rx_ecrc_err && mrd |=> cpl_valid && cpl_status == CPL_ST_CA)
    else $error("no abort completion");
  ecrc_drop_a: assert property (tk && rx_ecrc_err && !app_valid |=> !app_valid && !err_poison)
    else $error("ecrc packet forwarded");
  cfg0_func_a: assert property (ok && rx_type == TYP_CFG0 && rx_func >= NUM_FUNC |=> err_ur && err_nonfatal)
    else $error("missing function not flagged");
  cpl_owner_a: assert property (ok && rx_type == TYP_CPL && rx_req_id != cfg_bdf |=> err_ur && !cpl_valid)
    else $error("foreign completion not flagged");
  cfg1_ur_a: assert property (ok && rx_type == TYP_CFG1 |=> err_ur && cpl_valid && cpl_status == CPL_ST_UR)
    else $error("type 1 config not refused");
  lock_read_a: assert property (ok && rx_type == TYP_MEM_LK |=> err_ur)
    else $error("locked read not flagged");
  lock_cpl_a: assert property (ok && rx_type == TYP_CPL_LK |=> err_ur)
    else $error("locked completion not flagged");
  zero_upper_a: assert property (ok && rx_type == TYP_MEM && rx_fmt[FMT_4DW_BIT] && rx_addr[63:32] == ADDR_HI_ZERO |=> err_ur)
    else $error("zero upper address not flagged");
  mem_off_a: assert property (ok && rx_type == TYP_MEM && !cfg_command[CMD_MEM_EN_BIT] |=> err_ur)
    else $error("memory disabled not flagged");
  cfg_poison_a: assert property (ok && rx_type == TYP_CFG0 && rx_fmt[FMT_DATA_BIT] && rx_poison |=> err_ur && !err_poison)
    else $error("poisoned config write wrong");
  poison_fwd_a: assert property (err_poison |-> app_valid && !err_ur && !err_ecrc)
    else $error("poisoned packet not forwarded");
  cover property (tk && rx_ecrc_err && mrd);
  cover property (err_poison);
  cover property (cpl_valid && !cpl_ready);
endmodule // reh_rx_error_handler_chk
bind reh_rx_error_handler reh_rx_error_handler_chk #(.NUM_BAR(NUM_BAR), .NUM_FUNC(NUM_FUNC)) chk (.*);
`default_nettype wire

// ---- test/reh_rx_error_handler_test.sv ----
// Self-checking bench for the receive error handler
`default_nettype none
module reh_rx_error_handler_test import reh_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] M = 64'h0000_0001_0000_0040;
  localparam logic [7:0] MSGS [5] = '{MSG_UNLOCK, MSG_PME_OFF, MSG_SLOT_PWR, MSG_VDM0, MSG_VDM1};
  logic clk = 1'b0, reset_n = 1'b0, rx_valid = 1'b0, rx_poison = 1'b0, rx_ecrc_err = 1'b0, stall = 1'b0;
  logic [2:0] rx_fmt = 3'h0, rx_func = 3'h0;
  logic [4:0] rx_type = 5'h00;
  logic [7:0] rx_tag = 8'h00, rx_msg_code = 8'h00;
  logic [15:0] rx_req_id = 16'h0100, cfg_command = 16'h0002;
  logic [63:0] rx_addr = 64'h0;
  logic rx_ready, app_valid, app_ready, app_poison, cpl_valid, cpl_ready;
  logic err_poison, err_ecrc, err_ur, err_nonfatal;
  logic [2:0] app_fmt, cpl_status;
  logic [4:0] app_type;
  logic [7:0] app_tag, app_msg_code, cpl_tag;
  logic [15:0] app_req_id, cpl_req_id, cpl_cmpl_id;
  logic [63:0] app_addr;
  logic [104:0] app_q [$];
  logic [42:0] cpl_q [$];
  logic [3:0] err_q [$];
  int n_fail = 0, checks_done = 0;
  always #12.5 clk = ~clk;
  reh_rx_error_handler dut (.*, .cfg_bdf(16'h0100), .bar_base({64'h1000, 64'h1_0000_0000}),
    .bar_mask({64'hffff_ffff_ffff_ff00, 64'hffff_ffff_ffff_0000}), .bar_is_io(2'h2), .bar_en(2'h3));
  reh_app_model app (.*);
  task automatic fail(input string m);
    $display("unexpected at %0t: %0s", $time, m);
    n_fail++;
  endtask
  task automatic summarize();
    if (app_q.size() + cpl_q.size() + err_q.size() != 0) fail("results missing");
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_app(input logic [104:0] got);
    checks_done++;
    if (app_q.size() == 0) fail("extra forward");
    else if (app_q.pop_front() !== got) fail("forward mismatch");
  endtask
  task automatic cmp_cpl(input logic [42:0] got);
    checks_done++;
    if (cpl_q.size() == 0) fail("extra completion");
    else if (cpl_q.pop_front() !== got) fail("completion mismatch");
  endtask
  task automatic cmp_err(input logic [3:0] got);
    checks_done++;
    if (err_q.size() == 0) fail("extra error event");
    else if (err_q.pop_front() !== got) fail("error event mismatch");
  endtask
  // Sampled off the launching edge, with the values the next rising edge will see
  always @(negedge clk) begin
    if (reset_n && app_valid && app_ready)
      cmp_app({app_type, app_poison, app_tag, app_fmt, app_msg_code, app_req_id, app_addr});
    if (reset_n && cpl_valid && cpl_ready)
      cmp_cpl({cpl_status, cpl_tag, cpl_req_id, cpl_cmpl_id});
    if (reset_n && (err_poison || err_ecrc || err_ur || err_nonfatal))
      cmp_err({err_poison, err_ecrc, err_ur, err_nonfatal});
  end
  // Offer one header, note what must come out, hold until taken
  task automatic send(input logic [2:0] f, input logic [4:0] ty, input logic p, e,
                      input logic [63:0] a, input logic fw, input logic [2:0] cs);
    int i;
    {rx_fmt, rx_type, rx_poison, rx_ecrc_err, rx_addr, rx_valid} = {f, ty, p, e, a, 1'b1};
    rx_tag = rx_tag + 8'h01;
    if (fw) app_q.push_back({ty, p, rx_tag, f, rx_msg_code, rx_req_id, a});
    if (cs != 3'h0) cpl_q.push_back({cs, rx_tag, rx_req_id, 16'h0100});
    if (e) err_q.push_back(4'h5);
    else if (!fw) err_q.push_back(4'h3);
    else if (p) err_q.push_back(4'h8);
    for (i = 0; i < 64 && rx_ready !== 1'b1; i++) @(negedge clk);
    if (i == 64) fail("link stuck");
    if (i == 64) summarize();
    @(negedge clk);
  endtask
  initial begin
    int i;
    void'($urandom(18));
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    send(3'h3, TYP_MEM, 1, 0, M, 1, 0);
    send(3'h1, TYP_MEM, 0, 1, M, 0, CPL_ST_CA);
    send(3'h3, TYP_MEM, 0, 1, M, 0, 0);
    send(3'h1, TYP_MEM, 1, 1, M, 0, CPL_ST_CA);
    $display("poison and ecrc done");
    rx_func = 3'h1;
    send(3'h0, TYP_CFG0, 0, 0, 0, 0, CPL_ST_UR);
    rx_func = 3'h0;
    send(3'h0, TYP_CFG0, 0, 0, 0, 1, 0);
    rx_req_id = 16'h0200;
    send(3'h2, TYP_CPL, 0, 0, 0, 0, 0);
    rx_req_id = 16'h0100;
    send(3'h2, TYP_CPL, 0, 0, 0, 1, 0);
    rx_msg_code = 8'h33;
    send(3'h1, 5'h14, 0, 0, 0, 0, 0);
    for (i = 0; i < 5; i++) begin
      rx_msg_code = MSGS[i];
      send(3'h1, 5'h14, 0, 0, 0, 1, 0);
    end
    send(3'h0, TYP_CFG1, 0, 0, 0, 0, CPL_ST_UR);
    send(3'h1, TYP_MEM_LK, 0, 0, M, 0, CPL_ST_UR);
    send(3'h2, TYP_CPL_LK, 0, 0, 0, 0, 0);
    send(3'h2, TYP_CFG0, 1, 0, 0, 0, CPL_ST_UR);
    $display("unsupported kinds done");
    stall = 1'b1;
    send(3'h1, TYP_MEM, 0, 0, 64'h40, 0, CPL_ST_UR);
    send(3'h1, TYP_MEM, 0, 0, 64'h2_0000_0040, 0, CPL_ST_UR);
    send(3'h0, TYP_IO, 0, 0, 64'h1010, 1, 0);
    send(3'h0, TYP_IO, 0, 0, 64'h2010, 0, CPL_ST_UR);
    cfg_command = 16'h0000;
    send(3'h1, TYP_MEM, 0, 0, M, 0, CPL_ST_UR);
    send(3'h3, TYP_MEM, 0, 0, M, 0, 0);
    cfg_command = 16'h0002;
    $display("address checks done");
    for (i = 0; i < 24; i++) send(3'h3, TYP_MEM, 1'($urandom), 0, M | 64'($urandom % 65536), 1, 0);
    rx_valid = 1'b0;
    stall = 1'b0;
    for (i = 0; i < 200 && app_q.size() + cpl_q.size() + err_q.size() > 0; i++) @(negedge clk);
    $display("buffer stall done");
    summarize();
  end
endmodule // reh_rx_error_handler_test
`default_nettype wire
